// File: verilog/scl_pkg.sv
// constants and types shared by the lockable sense control registers
package scl_pkg;

	// ----------------------------------------------------------------
	// register bus shape
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BE_W = 4;
	localparam int unsigned REG_W = 8;
	localparam int unsigned IDX_W = 8;
	localparam logic WAIT_RST = 1'b1;
	localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_CTRL_FIVE = 8'h11;
	localparam logic [IDX_W-1:0] IDX_CTRL_SIX = 8'h12;
	localparam logic [IDX_W-1:0] IDX_STATUS = 8'h13;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_CTRL_FIVE = 8'h00;
	localparam logic [REG_W-1:0] RST_CTRL_SIX = 8'h40;
	localparam logic [REG_W-1:0] RST_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int unsigned BIT_DEADTIME_DIS = 7;
	localparam int unsigned BIT_UNLOCK = 5;
	localparam int unsigned SEL_MSB = 2;
	localparam int unsigned SEL_LSB = 0;
	localparam int unsigned BIT_TRIM_SRC = 6;
	localparam int unsigned BIT_GATE_OVR = 0;
	localparam int unsigned STAT_LOCKED = 0;
	localparam int unsigned STAT_BLOCKED = 1;
	localparam int unsigned STAT_CAL_AMP3 = 2;
	localparam int unsigned STAT_CAL_BEMF = 3;
	localparam int unsigned STAT_BACKEMF_SENSE_ENABLE = 4;

	// ----------------------------------------------------------------
	// monitor selector codes and one-hot route positions
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MON_GROUND = 3'h0,
		MON_TEMP = 3'h2,
		MON_AMP3_RES = 3'h4,
		MON_AMP1 = 3'h5,
		MON_AMP2 = 3'h6,
		MON_AMP3_DIRECT = 3'h7
	} scl_mon_code_e;

	localparam int unsigned ROUTE_W = 8;
	localparam int unsigned ROUTE_GND = 0;
	localparam int unsigned ROUTE_TEMP = 1;
	localparam int unsigned ROUTE_AMP1 = 2;
	localparam int unsigned ROUTE_AMP2 = 3;
	localparam int unsigned ROUTE_AMP3_RES = 4;
	localparam int unsigned ROUTE_AMP3_DIRECT = 5;
	localparam int unsigned ROUTE_BEMF_RES = 6;
	localparam int unsigned ROUTE_BEMF_DIRECT = 7;
	localparam logic [ROUTE_W-1:0] ROUTE_RST = 8'h01;

	// ----------------------------------------------------------------
	// calibration sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CAL_IDLE = 2'h0,
		CAL_AMP3 = 2'h1,
		CAL_BEMF = 2'h2
	} scl_cal_state_e;

endpackage

// File: verilog/scl_regbus_if.sv
// internal register access carrier between bus slave and register bank
interface scl_regbus_if;
	import scl_pkg::*;

	logic wr_strobe;
	logic [IDX_W-1:0] index;
	logic [REG_W-1:0] wdata;
	logic [REG_W-1:0] rdata;

	modport slave (
		output wr_strobe,
		output index,
		output wdata,
		input rdata
	);

	modport bank (
		input wr_strobe,
		input index,
		input wdata,
		output rdata
	);
endinterface

// File: verilog/scl_avmm_slave.sv
// avalon-mm slave front end with one wait state per access
module scl_avmm_slave (
	input wire logic clock,
	input wire logic reset,
	input wire logic [scl_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [scl_pkg::DATA_W-1:0] writedata,
	input wire logic [scl_pkg::BE_W-1:0] byteenable,
	output logic [scl_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	scl_regbus_if.slave bus
);
	import scl_pkg::*;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// registers live in byte lane 0; other lanes are ignored on write
	assign bus.index = address[ADDR_W-1:2];
	assign bus.wdata = writedata[REG_W-1:0];
	// write commits on the edge the master sees waitrequest low
	assign bus.wr_strobe = write && !waitrequest && byteenable[0];

	// ----------------------------------------------------------------
	// handshake
	// ----------------------------------------------------------------
	// held high at idle so a new request always sees one wait cycle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			waitrequest <= WAIT_RST;
		end else if ((read || write) && waitrequest) begin
			waitrequest <= 1'b0;
		end else begin
			waitrequest <= 1'b1;
		end
	end

	// read data captured one cycle ahead so it is stable at completion
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			readdata <= RDATA_RST;
		end else if (read && waitrequest) begin
			readdata <= {{(DATA_W-REG_W){1'b0}}, bus.rdata};
		end
	end
endmodule

// File: verilog/scl_monitor_mux.sv
// registered decoder of the analog monitor selector
module scl_monitor_mux (
	input wire logic clock,
	input wire logic reset,
	input wire logic [2:0] select,
	input wire logic backemf_sense_enable,
	output logic [scl_pkg::ROUTE_W-1:0] route
);
	import scl_pkg::*;

	logic [ROUTE_W-1:0] next_route;

	// ----------------------------------------------------------------
	// selector decode
	// ----------------------------------------------------------------
	// codes 001 and 011 have no source: pin left fully open
	always_comb begin
		next_route = '0;
		if (select == MON_GROUND) begin
			next_route[ROUTE_GND] = 1'b1;
		end else if (select == MON_TEMP) begin
			next_route[ROUTE_TEMP] = 1'b1;
		end else if (select == MON_AMP1) begin
			next_route[ROUTE_AMP1] = 1'b1;
		end else if (select == MON_AMP2) begin
			next_route[ROUTE_AMP2] = 1'b1;
		end else if (select == MON_AMP3_RES) begin
			if (backemf_sense_enable) begin
				next_route[ROUTE_BEMF_RES] = 1'b1;
			end else begin
				next_route[ROUTE_AMP3_RES] = 1'b1;
			end
		end else if (select == MON_AMP3_DIRECT) begin
			if (backemf_sense_enable) begin
				next_route[ROUTE_BEMF_DIRECT] = 1'b1;
			end else begin
				next_route[ROUTE_AMP3_DIRECT] = 1'b1;
			end
		end
	end

	// registered so the analog switches never see decode glitches
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			route <= ROUTE_RST;
		end else begin
			route <= next_route;
		end
	end
endmodule

// File: verilog/scl_sense_ctrl.sv
// top of the lockable sense control register pair with calibration sequencing
module scl_sense_ctrl (
	input wire logic clock,
	input wire logic reset,
	input wire logic [scl_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [scl_pkg::DATA_W-1:0] writedata,
	input wire logic [scl_pkg::BE_W-1:0] byteenable,
	output logic [scl_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic backemf_sense_enable,
	input wire logic amp3_calibrate_trigger,
	input wire logic cal_done_async,
	output logic adaptive_deadtime_disable,
	output logic backemf_trim_source,
	output logic gate_override_enable,
	output logic [scl_pkg::ROUTE_W-1:0] monitor_route,
	output logic amp3_cal_start,
	output logic bemf_cal_start,
	output logic amp3_cal_busy,
	output logic bemf_cal_busy
);
	import scl_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	scl_regbus_if bus ();

	logic [REG_W-1:0] sense_control_five;
	logic [REG_W-1:0] sense_control_six;
	logic [REG_W-1:0] status_word;
	logic blocked_write;
	scl_cal_state_e cal_state;
	scl_cal_state_e next_cal_state;
	logic done_meta;
	logic done_sync;
	logic done_last;
	logic done_rise;
	logic five_write;
	logic six_write;
	logic six_write_locked;
	logic status_write;
	logic cal_request;
	logic bemf_cal_finish;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// shared by write decode and read mux
	function automatic logic hits(input logic [IDX_W-1:0] index, input logic [IDX_W-1:0] target);
		hits = (index == target);
	endfunction

	// ----------------------------------------------------------------
	// bus front end
	// ----------------------------------------------------------------
	scl_avmm_slave u_slave (
		.clock(clock),
		.reset(reset),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.bus(bus.slave)
	);

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	assign five_write = bus.wr_strobe && hits(bus.index, IDX_CTRL_FIVE);
	assign six_write = bus.wr_strobe && hits(bus.index, IDX_CTRL_SIX)
		&& sense_control_five[BIT_UNLOCK];
	// locked writes complete normally on the bus, so no error is visible
	assign six_write_locked = bus.wr_strobe && hits(bus.index, IDX_CTRL_SIX)
		&& !sense_control_five[BIT_UNLOCK];
	assign status_write = bus.wr_strobe && hits(bus.index, IDX_STATUS);

	// ----------------------------------------------------------------
	// register five
	// ----------------------------------------------------------------
	// reserved bits are stored as written; software keeps them zero
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sense_control_five <= RST_CTRL_FIVE;
		end else if (five_write) begin
			sense_control_five <= bus.wdata;
		end
	end

	// ----------------------------------------------------------------
	// register six
	// ----------------------------------------------------------------
	// calibration end beats a same-cycle software write on the trim bit,
	// so fresh calibration data is never masked by a stale write
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sense_control_six <= RST_CTRL_SIX;
		end else begin
			if (six_write) begin
				sense_control_six <= bus.wdata;
			end
			if (bemf_cal_finish) begin
				sense_control_six[BIT_TRIM_SRC] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// blocked write flag
	// ----------------------------------------------------------------
	// write one clears it; a new blocked write in that cycle still sets it
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			blocked_write <= 1'b0;
		end else if (six_write_locked) begin
			blocked_write <= 1'b1;
		end else if (status_write && bus.wdata[STAT_BLOCKED]) begin
			blocked_write <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		status_word = RST_ZERO;
		status_word[STAT_LOCKED] = !sense_control_five[BIT_UNLOCK];
		status_word[STAT_BLOCKED] = blocked_write;
		status_word[STAT_CAL_AMP3] = (cal_state == CAL_AMP3);
		status_word[STAT_CAL_BEMF] = (cal_state == CAL_BEMF);
		status_word[STAT_BACKEMF_SENSE_ENABLE] = backemf_sense_enable;
	end

	// unmapped indices read as zero
	always_comb begin
		if (hits(bus.index, IDX_CTRL_FIVE)) begin
			bus.rdata = sense_control_five;
		end else if (hits(bus.index, IDX_CTRL_SIX)) begin
			bus.rdata = sense_control_six;
		end else if (hits(bus.index, IDX_STATUS)) begin
			bus.rdata = status_word;
		end else begin
			bus.rdata = RST_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// calibration done synchroniser
	// ----------------------------------------------------------------
	// done comes from the analog side with no relation to our clock
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			done_meta <= 1'b0;
			done_sync <= 1'b0;
			done_last <= 1'b0;
		end else begin
			done_meta <= cal_done_async;
			done_sync <= done_meta;
			done_last <= done_sync;
		end
	end

	assign done_rise = done_sync && !done_last;

	// ----------------------------------------------------------------
	// calibration sequencer
	// ----------------------------------------------------------------
	// a trigger while busy is dropped; one calibration runs at a time
	assign cal_request = amp3_calibrate_trigger && (cal_state == CAL_IDLE);
	assign bemf_cal_finish = (cal_state == CAL_BEMF) && done_rise;

	always_comb begin
		next_cal_state = cal_state;
		unique case (cal_state)
			CAL_IDLE: begin
				if (cal_request && backemf_sense_enable) begin
					next_cal_state = CAL_BEMF;
				end else if (cal_request) begin
					next_cal_state = CAL_AMP3;
				end
			end
			CAL_AMP3: begin
				if (done_rise) begin
					next_cal_state = CAL_IDLE;
				end
			end
			CAL_BEMF: begin
				if (done_rise) begin
					next_cal_state = CAL_IDLE;
				end
			end
			default: begin
				next_cal_state = CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cal_state <= CAL_IDLE;
		end else begin
			cal_state <= next_cal_state;
		end
	end

	// ----------------------------------------------------------------
	// calibration outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			amp3_cal_start <= 1'b0;
			bemf_cal_start <= 1'b0;
		end else begin
			amp3_cal_start <= cal_request && !backemf_sense_enable;
			bemf_cal_start <= cal_request && backemf_sense_enable;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			amp3_cal_busy <= 1'b0;
			bemf_cal_busy <= 1'b0;
		end else begin
			amp3_cal_busy <= (next_cal_state == CAL_AMP3);
			bemf_cal_busy <= (next_cal_state == CAL_BEMF);
		end
	end

	// ----------------------------------------------------------------
	// control outputs
	// ----------------------------------------------------------------
	// separate flops keep the outputs registered and one cycle behind
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			adaptive_deadtime_disable <= 1'b0;
			backemf_trim_source <= 1'b1;
			gate_override_enable <= 1'b0;
		end else begin
			adaptive_deadtime_disable <= sense_control_five[BIT_DEADTIME_DIS];
			backemf_trim_source <= sense_control_six[BIT_TRIM_SRC];
			gate_override_enable <= sense_control_six[BIT_GATE_OVR];
		end
	end

	// ----------------------------------------------------------------
	// analog monitor routing
	// ----------------------------------------------------------------
	scl_monitor_mux u_monitor (
		.clock(clock),
		.reset(reset),
		.select(sense_control_five[SEL_MSB:SEL_LSB]),
		.backemf_sense_enable(backemf_sense_enable),
		.route(monitor_route)
	);
endmodule

// File: tb/scl_sense_ctrl_sva.sv
// concurrent checks on the ports of the lockable sense control registers
module scl_sense_ctrl_sva (
	input wire logic clock,
	input wire logic reset,
	input wire logic [scl_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [scl_pkg::DATA_W-1:0] writedata,
	input wire logic [scl_pkg::BE_W-1:0] byteenable,
	input wire logic [scl_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	input wire logic backemf_sense_enable,
	input wire logic amp3_calibrate_trigger,
	input wire logic cal_done_async,
	input wire logic adaptive_deadtime_disable,
	input wire logic backemf_trim_source,
	input wire logic gate_override_enable,
	input wire logic [scl_pkg::ROUTE_W-1:0] monitor_route,
	input wire logic amp3_cal_start,
	input wire logic bemf_cal_start,
	input wire logic bemf_cal_busy,
	input wire logic amp3_cal_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	import scl_pkg::*;
	// ----------------------------------------------------------------
	// shadow of what software committed
	// ----------------------------------------------------------------
	logic wr_ok;
	logic [7:0] ix;
	logic [7:0] five;
	logic gate;
	logic armed;
	assign ix = address[9:2];
	// the edge that releases reset still sees reset-time history through $past
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end
	assign wr_ok = write && !waitrequest && byteenable[0];
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			five <= RST_CTRL_FIVE;
			gate <= 1'b0;
		end else if (wr_ok) begin
			if (ix == IDX_CTRL_FIVE)
				five <= writedata[7:0];
			// shadow follows the lock, so a locked write must not move the output
			if (ix == IDX_CTRL_SIX && five[BIT_UNLOCK])
				gate <= writedata[0];
		end
	end
	function automatic logic [7:0] route_of(input logic [2:0] s, input logic b);
		case (s)
			3'h0: return 8'h01;
			3'h2: return 8'h02;
			3'h5: return 8'h04;
			3'h6: return 8'h08;
			3'h4: return b ? 8'h40 : 8'h10;
			3'h7: return b ? 8'h80 : 8'h20;
			default: return 8'h00;
		endcase
	endfunction
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset || !armed);
	chk_wait_once: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered in one cycle");
	chk_deadtime_out: assert property (adaptive_deadtime_disable == $past(five[7]))
		else $error("dead time disable does not follow register five");
	chk_lock_gate: assert property (gate_override_enable == $past(gate))
		else $error("gate override does not follow unlocked writes");
	chk_route_code: assert property (monitor_route ==
		route_of($past(five[2:0]), $past(backemf_sense_enable)))
		else $error("monitor route does not match selector");
	chk_five_read: assert property (read && !waitrequest && ix == IDX_CTRL_FIVE
		|-> readdata == {24'h0, five})
		else $error("register five read mismatch");
	chk_six_read: assert property (read && !waitrequest && ix == IDX_CTRL_SIX
		|-> readdata[0] == gate)
		else $error("register six read mismatch");
	chk_cal_kind: assert property (amp3_calibrate_trigger
		&& !$past(amp3_calibrate_trigger)
		&& !amp3_cal_busy && !bemf_cal_busy |=> bemf_cal_start == $past(backemf_sense_enable)
		&& amp3_cal_start != $past(backemf_sense_enable))
		else $error("wrong calibration started");
	// the trim output is a registered copy, so it drops one edge after busy
	chk_trim_clear: assert property ($fell(bemf_cal_busy) |=> !backemf_trim_source)
		else $error("trim source not cleared after calibration");
	chk_cal_end: assert property ($rose(cal_done_async) && bemf_cal_busy
		|-> ##[2:6] !bemf_cal_busy)
		else $error("calibration busy did not end");
	cov_bemf: cover property (bemf_cal_start);
	cov_amp3: cover property (amp3_cal_start);
	cov_locked: cover property (wr_ok && ix == IDX_CTRL_SIX && !five[BIT_UNLOCK]);
	cov_route: cover property (monitor_route[7]);
endmodule

bind scl_sense_ctrl scl_sense_ctrl_sva u_sva (.clock, .reset, .address, .read, .write,
	.writedata, .byteenable, .readdata, .waitrequest, .backemf_sense_enable,
	.amp3_calibrate_trigger, .cal_done_async, .adaptive_deadtime_disable,
	.backemf_trim_source, .gate_override_enable, .monitor_route, .amp3_cal_start,
	.bemf_cal_start, .bemf_cal_busy, .amp3_cal_busy);

// File: tb/scl_sense_ctrl_tb.sv
// self-checking bench of the lockable sense control registers
module scl_sense_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import scl_pkg::*;
	logic clock, reset, read, write, backemf_sense_enable, amp3_calibrate_trigger;
	logic cal_done_async, adaptive_deadtime_disable, backemf_trim_source;
	logic gate_override_enable, amp3_cal_start, bemf_cal_start, amp3_cal_busy, bemf_cal_busy;
	logic [ADDR_W-1:0] address;
	logic [DATA_W-1:0] writedata, readdata;
	logic [BE_W-1:0] byteenable;
	logic waitrequest;
	logic [ROUTE_W-1:0] monitor_route;
	logic [31:0] seed = 32'h1f;
	logic [31:0] exp_q[$];
	int num_errors = 0;
	int checked = 0;
	// index is {backemf enable, selector}
	logic [7:0] route_tbl[16] = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h10, 8'h04, 8'h08, 8'h20,
		8'h01, 8'h00, 8'h02, 8'h00, 8'h40, 8'h04, 8'h08, 8'h80};
	scl_sense_ctrl uut (.clock, .reset, .address, .read, .write, .writedata, .byteenable,
		.readdata, .waitrequest, .backemf_sense_enable, .amp3_calibrate_trigger,
		.cal_done_async, .adaptive_deadtime_disable, .backemf_trim_source,
		.gate_override_enable, .monitor_route, .amp3_cal_start, .bemf_cal_start,
		.amp3_cal_busy, .bemf_cal_busy);
	always #2.5 clock = ~clock;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one bus cycle; a hang is left to the watchdog
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		@(posedge clock);
		while (waitrequest)
			@(posedge clock);
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// unlock, write six, lock again
	task automatic six(input logic [7:0] d);
		bus(1'b1, 10'h044, 32'h20);
		bus(1'b1, 10'h048, {24'h0, d});
		bus(1'b1, 10'h044, 32'h00);
	endtask
	task automatic cal(input logic b);
		backemf_sense_enable <= b;
		amp3_calibrate_trigger <= 1'b1;
		@(posedge clock);
		amp3_calibrate_trigger <= 1'b0;
		@(posedge clock);
		chk({amp3_cal_start, bemf_cal_start}, {~b, b});
		repeat (3) @(posedge clock);
		chk({amp3_cal_busy, bemf_cal_busy}, {~b, b});
		rd(10'h04c, {27'h0, b, b, ~b, 2'h1});
		cal_done_async <= 1'b1;
		repeat (10) if (amp3_cal_busy || bemf_cal_busy) @(posedge clock);
		chk({amp3_cal_busy, bemf_cal_busy}, 32'h0);
		cal_done_async <= 1'b0;
		@(posedge clock);
	endtask
	// ----------------------------------------------------------------
	// read results leave the queue in order
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (read && !waitrequest)
			chk(readdata, exp_q.pop_front());
	end
	// a few hundred cycles are needed; this bound is generous
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] v;
		logic [7:0] d;
		clock = 1'b0;
		reset = 1'b1;
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'hf;
		backemf_sense_enable = 1'b0;
		amp3_calibrate_trigger = 1'b0;
		cal_done_async = 1'b0;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(10'h044, 32'h00);
		rd(10'h048, 32'h40);
		chk({monitor_route, backemf_trim_source, gate_override_enable}, 32'h006);
		v = xs();
		bus(1'b1, 10'h048, {24'h0, 1'b0, ~v[1], 5'h0, 1'b1});
		rd(10'h048, 32'h40);
		chk(gate_override_enable, 32'h0);
		rd(10'h04c, 32'h03);
		bus(1'b1, 10'h04c, 32'h02);
		rd(10'h04c, 32'h01);
		six(8'h41);
		rd(10'h048, 32'h41);
		chk(gate_override_enable, 32'h1);
		chk(backemf_trim_source, 32'h1);
		byteenable <= 4'h0;
		bus(1'b1, 10'h044, 32'h20);
		byteenable <= 4'hf;
		rd(10'h044, 32'h00);
		bus(1'b1, 10'h3fc, 32'hff);
		rd(10'h3fc, 32'h00);
		for (int i = 0; i < 16; i++) begin
			v = xs();
			d = {v[0], 4'h0, i[2:0]};
			backemf_sense_enable <= i[3];
			bus(1'b1, 10'h044, {24'h0, d});
			rd(10'h044, {24'h0, d});
			chk(monitor_route, route_tbl[i]);
			chk(adaptive_deadtime_disable, v[0]);
		end
		cal(1'b1);
		rd(10'h048, 32'h01);
		chk(backemf_trim_source, 32'h0);
		six(8'h41);
		cal(1'b0);
		rd(10'h048, 32'h41);
		repeat (2) @(posedge clock);
		print_verdict();
	end
endmodule
